//--- rtl/ftb_sram_ctrl.sv
// Flow-through burst SRAM: access control, burst addressing and storage array
// Functional notes
// R1: Array holds 512K x 36 or 1M x 18 words on common data pins.
// R2: All synchronous inputs are sampled on the rising clock edge.
// R3: Address and chip selects are captured when either address strobe is active.
// R4: A burst starts from the processor strobe or the controller strobe.
// R5: A 2-bit counter loads the first low address bits, then supplies the rest.
// R6: Burst address advances only when advance is asserted, otherwise it holds.
// R7: Order select high gives interleaved order, low gives linear order.
// R8: Output enable and sleep act without waiting for a clock edge.
// R9: A four-beat burst runs at two, one, one, one clocks per beat.
// R10: Linear adds the beat modulo four; interleaved xors the beat.
// R11: Read data follows the registered address with no output register stage.
`include "ftb_params.svh"

module ftb_sram_ctrl #(
  parameter logic P_ORG_WIDE = `FTB_ORG_WIDE
) (
  // Clock and reset
  input  wire logic                         i_ref_clk,
  input  wire logic                         i_rst,
  // Address and strobes
  input  wire logic [`FTB_ADDR_W_MAX-1:0]   i_addr,
  input  wire logic                         i_proc_addr_strobe_n,
  input  wire logic                         i_ctrl_addr_strobe_n,
  input  wire logic                         i_burst_advance_n,
  input  wire logic                         i_burst_order,
  // Chip selects
  input  wire logic                         i_chip_sel_primary_n,
  input  wire logic                         i_chip_sel_depth_a,
  input  wire logic                         i_chip_sel_depth_b_n,
  // Write enables
  input  wire logic [`FTB_LANES_MAX-1:0]    i_lane_write_n,
  input  wire logic                         i_lane_write_gate_n,
  input  wire logic                         i_all_lanes_write_n,
  // Asynchronous controls
  input  wire logic                         i_out_enable_n,
  input  wire logic                         i_sleep_req,
  // Data pins
  input  wire logic [`FTB_DATA_W_MAX-1:0]   i_dq,
  output logic      [`FTB_DATA_W_MAX-1:0]   o_dq,
  output logic                              o_dq_oe
);
  import ftb_pkg::*;

  // ------------------------------------------------------------
  // Organisation
  // ------------------------------------------------------------
  localparam int AW    = P_ORG_WIDE ? `FTB_ADDR_W_WIDE : `FTB_ADDR_W_NARROW;           // R1
  localparam int LANES = P_ORG_WIDE ? `FTB_LANES_WIDE : `FTB_LANES_NARROW;             // R1
  localparam int BW    = `FTB_ADDR_W_MAX - `FTB_CNT_W;

  // Narrow organisation leaves the upper lanes unused; they never write and read zero
  function automatic logic [`FTB_DATA_W_MAX-1:0] lane_mask(input logic [`FTB_LANES_MAX-1:0] en);
    logic [`FTB_DATA_W_MAX-1:0] m;
    m = '0;
    for (int l = 0; l < `FTB_LANES_MAX; l++) begin
      if (l < LANES && en[l]) begin
        m[l*`FTB_LANE_W +: `FTB_LANE_W] = {`FTB_LANE_W{1'b1}};
      end
    end
    return m;
  endfunction : lane_mask

  // ------------------------------------------------------------
  // Burst counter
  // ------------------------------------------------------------
  ftb_burst_if burst ();

  ftb_burst_counter u_counter (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .bus       (burst)
  );

  // ------------------------------------------------------------
  // Access control
  // ------------------------------------------------------------
  ftb_state_t                   state_q, state_d;
  logic [BW-1:0]                base_q, base_d;
  logic [`FTB_ADDR_W_MAX-1:0]   addr_q, addr_d;
  logic [`FTB_LANES_MAX-1:0]    lane_wr;
  logic                         start;
  logic                         selected;
  logic                         wr_any;

  always_comb begin
    selected = !i_chip_sel_primary_n && i_chip_sel_depth_a && !i_chip_sel_depth_b_n;
    start    = (!i_proc_addr_strobe_n || !i_ctrl_addr_strobe_n) && !i_sleep_req;   // R4
    for (int l = 0; l < `FTB_LANES_MAX; l++) begin
      lane_wr[l] = !i_all_lanes_write_n || (!i_lane_write_gate_n && !i_lane_write_n[l]);
    end
    wr_any = |lane_mask(lane_wr);

    burst.interleave = i_burst_order;                                               // R7
    burst.seed       = i_addr[`FTB_CNT_W-1:0];
    burst.load       = start && selected;                                           // R5
    burst.step       = !start && !i_burst_advance_n && state_q != FTB_DESEL;        // R6

    state_d = state_q;
    base_d  = base_q;
    addr_d  = addr_q;
    if (i_sleep_req) begin
      state_d = FTB_DESEL;
    end else if (start) begin
      if (!selected) begin
        state_d = FTB_DESEL;                                                        // R3
      end else begin
        base_d = i_addr[`FTB_ADDR_W_MAX-1:`FTB_CNT_W];                              // R3
        addr_d = i_addr;                                                            // R3
        // Processor strobe always opens with a read; writes follow on later edges
        if (!i_proc_addr_strobe_n) begin
          state_d = FTB_READ;
        end else begin
          state_d = wr_any ? FTB_WRITE : FTB_READ;
        end
      end
    end else if (state_q != FTB_DESEL) begin
      addr_d  = {base_q, burst.step ? burst.low_next : burst.low};                  // R6
      state_d = wr_any ? FTB_WRITE : FTB_READ;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin                             // R2
    if (i_rst) begin
      state_q <= FTB_DESEL;
      base_q  <= '0;
      addr_q  <= '0;
    end else begin
      state_q <= state_d;
      base_q  <= base_d;
      addr_q  <= addr_d;
    end
  end

  // ------------------------------------------------------------
  // Storage array
  // ------------------------------------------------------------
  logic [`FTB_DATA_W_MAX-1:0] mem [0:(2**AW)-1];
  logic [`FTB_DATA_W_MAX-1:0] wr_mask;

  always_comb begin
    wr_mask = (state_d == FTB_WRITE) ? lane_mask(lane_wr) : '0;
  end

  // Write data is taken on the same edge as the address it belongs to
  always_ff @(posedge i_ref_clk) begin                                              // R2
    if (|wr_mask) begin
      mem[addr_d[AW-1:0]] <= (mem[addr_d[AW-1:0]] & ~wr_mask) | (i_dq & wr_mask);
    end
  end

  // ------------------------------------------------------------
  // Data pins
  // ------------------------------------------------------------
  // Flow-through read: array output reaches the pins in the cycle the address lands.
  // This trades clock-to-out time for one cycle less latency.
  assign o_dq    = mem[addr_q[AW-1:0]] & lane_mask({`FTB_LANES_MAX{1'b1}});         // R9 R11
  // Output enable and sleep bypass the clock so the bus frees at once
  assign o_dq_oe = (state_q == FTB_READ) && !i_out_enable_n && !i_sleep_req;        // R8

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  chk_strobe_capture: assert property ( // R3
    @(posedge i_ref_clk) disable iff (i_rst)
    (start && selected) |=> (addr_q == $past(i_addr)) && (state_q != FTB_DESEL))
    else $error("address not captured on an address strobe");

  chk_ctrl_strobe_start: assert property ( // R4
    @(posedge i_ref_clk) disable iff (i_rst)
    (!i_ctrl_addr_strobe_n && i_proc_addr_strobe_n && selected && !i_sleep_req && !wr_any)
    |=> state_q == FTB_READ)
    else $error("controller strobe did not start a read burst");

  chk_deselect: assert property ( // R3
    @(posedge i_ref_clk) disable iff (i_rst)
    (start && !selected) |=> state_q == FTB_DESEL && !o_dq_oe)
    else $error("deselected access left the device active");

  chk_hold_no_step: assert property ( // R6
    @(posedge i_ref_clk) disable iff (i_rst)
    (state_q != FTB_DESEL && !start && i_burst_advance_n && !i_sleep_req) |=> $stable(addr_q))
    else $error("burst address moved without advance");

  chk_step_moves: assert property ( // R6
    @(posedge i_ref_clk) disable iff (i_rst)
    (state_q != FTB_DESEL && !start && !i_burst_advance_n && !i_sleep_req)
    |=> addr_q[`FTB_ADDR_W_MAX-1:`FTB_CNT_W] == $past(base_q) && !$stable(addr_q))
    else $error("advance did not step the burst address");

  chk_oe_async: assert property ( // R8
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_out_enable_n || i_sleep_req) |-> !o_dq_oe)
    else $error("data pins driven while disabled or asleep");

  chk_flow_through: assert property ( // R11
    @(posedge i_ref_clk) disable iff (i_rst)
    (state_q == FTB_WRITE && !$past(i_all_lanes_write_n) ##1
     (state_q == FTB_READ && $stable(addr_q)))
    |-> o_dq == ($past(i_dq, 2) & lane_mask({`FTB_LANES_MAX{1'b1}})))
    else $error("read data does not follow the registered address");

  chk_first_beat: assert property ( // R9
    @(posedge i_ref_clk) disable iff (i_rst)
    (start && selected && !i_proc_addr_strobe_n && !i_out_enable_n) ##1 !i_out_enable_n && !i_sleep_req
    |-> o_dq_oe && addr_q == $past(i_addr))
    else $error("first beat not on the pins one clock after the strobe");

  chk_narrow_lanes: assert property ( // R1
    @(posedge i_ref_clk) disable iff (i_rst)
    !P_ORG_WIDE |-> o_dq[`FTB_DATA_W_MAX-1:`FTB_LANES_NARROW*`FTB_LANE_W] == '0)
    else $error("unused upper lanes not zero in narrow organisation");

  chk_sleep_desel: assert property ( // R8
    @(posedge i_ref_clk) disable iff (i_rst)
    i_sleep_req |=> state_q == FTB_DESEL)
    else $error("sleep did not deselect the device");

  chk_proc_read_only: assert property ( // R4
    @(posedge i_ref_clk) disable iff (i_rst)
    (start && selected && !i_proc_addr_strobe_n) |=> state_q == FTB_READ)
    else $error("processor strobe start did not open with a read");

  chk_cont_write: assert property ( // R2
    @(posedge i_ref_clk) disable iff (i_rst)
    (state_q != FTB_DESEL && !start && !i_all_lanes_write_n && !i_sleep_req) |=> state_q == FTB_WRITE)
    else $error("global write in a burst did not write");

endmodule : ftb_sram_ctrl

//--- rtl/ftb_params.svh
// Constants of the flow-through burst SRAM control logic
`ifndef FTB_PARAMS_SVH
`define FTB_PARAMS_SVH

// ------------------------------------------------------------
// Organisation
// ------------------------------------------------------------
`define FTB_ORG_WIDE      1'b1
`define FTB_ADDR_W_WIDE   19
`define FTB_ADDR_W_NARROW 20
`define FTB_ADDR_W_MAX    20
`define FTB_DATA_W_MAX    36
`define FTB_LANE_W        9
`define FTB_LANES_WIDE    4
`define FTB_LANES_NARROW  2
`define FTB_LANES_MAX     4

// ------------------------------------------------------------
// Burst counter
// ------------------------------------------------------------
`define FTB_CNT_W         2
`define FTB_CNT_RST       2'h0
`define FTB_CNT_ONE       2'h1
`define FTB_BURST_LEN     4

`endif

//--- rtl/ftb_pkg.sv
// Types and helpers of the flow-through burst SRAM control logic
`include "ftb_params.svh"

package ftb_pkg;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef logic [`FTB_CNT_W-1:0] ftb_cnt_t;

  typedef enum logic [1:0] {
    FTB_DESEL = 2'b00,
    FTB_READ  = 2'b01,
    FTB_WRITE = 2'b10
  } ftb_state_t;

  // ------------------------------------------------------------
  // Burst order: low address bits for a given beat
  // ------------------------------------------------------------
  function automatic ftb_cnt_t ftb_burst_bits(input ftb_cnt_t seed, input ftb_cnt_t beat, input logic interleave);
    ftb_cnt_t r;
    r = interleave ? (seed ^ beat) : ftb_cnt_t'(seed + beat);
    return r;
  endfunction : ftb_burst_bits

endpackage : ftb_pkg

//--- rtl/ftb_burst_if.sv
// Link between the access control and the burst counter
interface ftb_burst_if;
  import ftb_pkg::*;
  logic     load;
  logic     step;
  logic     interleave;
  ftb_cnt_t seed;
  ftb_cnt_t low;
  ftb_cnt_t low_next;

  modport ctrl (output load, output step, output interleave, output seed, input low, input low_next);
  modport cnt  (input load, input step, input interleave, input seed, output low, output low_next);
endinterface : ftb_burst_if

//--- rtl/ftb_burst_counter.sv
// Two-bit burst address counter with linear and interleaved order
`include "ftb_params.svh"

module ftb_burst_counter (
  // Clock and reset
  input  wire logic  i_ref_clk,
  input  wire logic  i_rst,
  // Control side
  ftb_burst_if.cnt   bus
);
  import ftb_pkg::*;

  ftb_cnt_t seed_q, seed_d;
  ftb_cnt_t beat_q, beat_d;

  always_comb begin
    seed_d = seed_q;
    beat_d = beat_q;
    if (bus.load) begin
      seed_d = bus.seed;                                  // R5
      beat_d = `FTB_CNT_RST;
    end else if (bus.step) begin
      beat_d = ftb_cnt_t'(beat_q + `FTB_CNT_ONE);         // R6
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      seed_q <= `FTB_CNT_RST;
      beat_q <= `FTB_CNT_RST;
    end else begin
      seed_q <= seed_d;
      beat_q <= beat_d;
    end
  end

  // Order pin is a static strap, so it is read live rather than latched
  assign bus.low      = ftb_burst_bits(seed_q, beat_q, bus.interleave);                            // R7 R10
  assign bus.low_next = ftb_burst_bits(seed_q, ftb_cnt_t'(beat_q + `FTB_CNT_ONE), bus.interleave); // R10

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  chk_load_seed: assert property ( // R5
    @(posedge i_ref_clk) disable iff (i_rst) bus.load |=> bus.low == $past(bus.seed))
    else $error("burst counter did not load the first address bits");

  chk_linear_step: assert property ( // R10
    @(posedge i_ref_clk) disable iff (i_rst)
    (bus.step && !bus.interleave && $stable(bus.interleave)) |=> bus.low == ftb_cnt_t'($past(bus.low) + 2'h1))
    else $error("linear order did not increment by one");

  chk_interleave_xor: assert property ( // R7
    @(posedge i_ref_clk) disable iff (i_rst)
    (bus.load && bus.interleave) ##1 (bus.step && bus.interleave) |=> bus.low == (seed_q ^ 2'h1))
    else $error("interleaved second beat is not seed xor one");

  chk_four_beat: assert property ( // R9
    @(posedge i_ref_clk) disable iff (i_rst)
    (bus.load ##1 (bus.step && !bus.load)[*4]) |=> bus.low == seed_q)
    else $error("four-beat burst did not wrap back to the first address");

endmodule : ftb_burst_counter

//--- bench/ftb_host_model.sv
// Host side model: a processor or cache controller driving the SRAM pins
`include "ftb_params.svh"

module ftb_host_model (
  // Clock
  input  wire logic                       i_ref_clk,
  // Address and burst control
  output logic [`FTB_ADDR_W_MAX-1:0]      o_addr,
  output logic                            o_proc_addr_strobe_n,
  output logic                            o_ctrl_addr_strobe_n,
  output logic                            o_burst_advance_n,
  output logic                            o_burst_order,
  // Selects and writes
  output logic                            o_chip_sel_primary_n,
  output logic                            o_chip_sel_depth_a,
  output logic                            o_chip_sel_depth_b_n,
  output logic [`FTB_LANES_MAX-1:0]       o_lane_write_n,
  output logic                            o_lane_write_gate_n,
  output logic                            o_all_lanes_write_n,
  // Asynchronous controls and data
  output logic                            o_out_enable_n,
  output logic                            o_sleep_req,
  output logic [`FTB_DATA_W_MAX-1:0]      o_dq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] sel;

  initial begin
    sel = 3'b010;
    {o_proc_addr_strobe_n, o_ctrl_addr_strobe_n, o_burst_advance_n} = 3'b111;
    {o_chip_sel_primary_n, o_chip_sel_depth_a, o_chip_sel_depth_b_n} = 3'b010;
    {o_lane_write_gate_n, o_all_lanes_write_n, o_lane_write_n} = 6'h3f;
    {o_out_enable_n, o_sleep_req, o_burst_order} = 3'b000;
    o_addr = '0;
    o_dq = '0;
  end

  task automatic ctl(input logic oe_n, input logic slp, input logic ord);
    @(posedge i_ref_clk);
    o_out_enable_n <= oe_n;
    o_sleep_req    <= slp;
    o_burst_order  <= ord;
  endtask : ctl

  // Released lines show the inverse of their last value, never a stale copy
  task automatic beat(input logic ps, input logic cs, input logic step, input logic [3:0] lw_n,
                      input logic [19:0] a, input logic [35:0] d);
    logic full;
    full = (lw_n == 4'h0);
    @(posedge i_ref_clk);
    o_proc_addr_strobe_n <= ~ps;
    o_ctrl_addr_strobe_n <= ~cs;
    o_burst_advance_n    <= ~step;
    {o_chip_sel_primary_n, o_chip_sel_depth_a, o_chip_sel_depth_b_n} <= sel;
    o_addr               <= (ps | cs) ? a : ~o_addr;
    o_all_lanes_write_n  <= ~full;
    o_lane_write_gate_n  <= full | (&lw_n);
    o_lane_write_n       <= lw_n;
    o_dq                 <= (&lw_n) ? ~o_dq : d;
  endtask : beat
endmodule : ftb_host_model

//--- bench/testbench.sv
// Self-checking bench of the flow-through burst SRAM control logic
`include "ftb_params.svh"

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import ftb_pkg::*;
  logic i_ref_clk, i_rst, i_proc_addr_strobe_n, i_ctrl_addr_strobe_n, i_burst_advance_n, i_burst_order;
  logic i_chip_sel_primary_n, i_chip_sel_depth_a, i_chip_sel_depth_b_n, i_lane_write_gate_n;
  logic i_all_lanes_write_n, i_out_enable_n, i_sleep_req, o_dq_oe;
  logic [19:0] i_addr;
  logic [3:0]  i_lane_write_n;
  logic [35:0] i_dq, o_dq;
  int          failures;
  int          samples_checked;
  logic [19:0] base [2] = '{20'h0_1231, 20'h0_4562};
  logic [2:0]  bad [3] = '{3'b110, 3'b000, 3'b011};

  ftb_sram_ctrl uut (.i_ref_clk, .i_rst, .i_addr, .i_proc_addr_strobe_n, .i_ctrl_addr_strobe_n,
    .i_burst_advance_n, .i_burst_order, .i_chip_sel_primary_n, .i_chip_sel_depth_a, .i_chip_sel_depth_b_n,
    .i_lane_write_n, .i_lane_write_gate_n, .i_all_lanes_write_n, .i_out_enable_n, .i_sleep_req,
    .i_dq, .o_dq, .o_dq_oe);

  ftb_host_model host (.i_ref_clk, .o_addr(i_addr), .o_proc_addr_strobe_n(i_proc_addr_strobe_n),
    .o_ctrl_addr_strobe_n(i_ctrl_addr_strobe_n), .o_burst_advance_n(i_burst_advance_n),
    .o_burst_order(i_burst_order), .o_chip_sel_primary_n(i_chip_sel_primary_n),
    .o_chip_sel_depth_a(i_chip_sel_depth_a), .o_chip_sel_depth_b_n(i_chip_sel_depth_b_n),
    .o_lane_write_n(i_lane_write_n), .o_lane_write_gate_n(i_lane_write_gate_n),
    .o_all_lanes_write_n(i_all_lanes_write_n), .o_out_enable_n(i_out_enable_n),
    .o_sleep_req(i_sleep_req), .o_dq(i_dq));

  initial i_ref_clk = 1'b0;
  always #20 i_ref_clk = ~i_ref_clk;

  // ----------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------
  function automatic logic [35:0] pat(input logic [19:0] a);
    return {16'hc3a5, a};
  endfunction : pat

  function automatic logic [19:0] baddr(input logic [19:0] a, input int k, input logic il);
    logic [1:0] n;
    n = il ? (a[1:0] ^ 2'(k)) : 2'(a[1:0] + 2'(k));
    return {a[19:2], n};
  endfunction : baddr

  task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim

  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  // Four beats back to back; each result is seen one clock after its edge
  task automatic t_burst(input logic wr, input logic [19:0] a, input logic ord);
    host.ctl(1'b0, 1'b0, ord);
    // Reads take a fourth advance so the counter wraps back to the first address
    for (int k = 0; k < (wr ? 5 : 6); k++) begin
      host.beat(1'b0, k == 0, (k inside {[1:3]}) || (!wr && k == 4), (wr && k < 4) ? 4'h0 : 4'hf, a,
                pat(baddr(a, k, ord)));
      @(negedge i_ref_clk);
      if (k > 0) begin
        check("drive enable", 36'(o_dq_oe), 36'(!wr));
        if (!wr) check("burst data", o_dq, pat(baddr(a, k - 1, ord)));
      end
    end
  endtask : t_burst

  task automatic t_hold_proc(input logic [19:0] a, input logic [19:0] b);
    host.beat(1'b0, 1'b1, 1'b0, 4'hf, a, '0);
    repeat (2) host.beat(1'b0, 1'b0, 1'b0, 4'hf, a, '0);
    @(negedge i_ref_clk);
    check("held data", o_dq, pat(a));
    host.beat(1'b1, 1'b0, 1'b0, 4'hf, b, '0);
    host.beat(1'b0, 1'b0, 1'b0, 4'he, b, 36'h0_0000_015a);
    @(negedge i_ref_clk);
    check("processor start data", o_dq, pat(b));
    host.beat(1'b0, 1'b1, 1'b0, 4'hf, b, '0);
    host.beat(1'b0, 1'b0, 1'b0, 4'hf, b, '0);
    @(negedge i_ref_clk);
    check("lane write", o_dq, (pat(b) & ~36'h0_0000_01ff) | 36'h0_0000_015a);
  endtask : t_hold_proc

  // Each control lands on an edge; a registered path would still show the old level
  task automatic t_async(input logic [19:0] a);
    host.beat(1'b0, 1'b1, 1'b0, 4'hf, a, '0);
    host.beat(1'b0, 1'b0, 1'b0, 4'hf, a, '0);
    host.ctl(1'b1, 1'b0, 1'b0);
    #1 check("enable off", 36'(o_dq_oe), 36'h0);
    host.ctl(1'b0, 1'b0, 1'b0);
    #1 check("enable on", 36'(o_dq_oe), 36'h1);
    host.ctl(1'b0, 1'b1, 1'b0);
    #1 check("sleep", 36'(o_dq_oe), 36'h0);
    host.ctl(1'b0, 1'b0, 1'b0);
    #1 check("after sleep", 36'(o_dq_oe), 36'h0);
  endtask : t_async

  task automatic t_desel(input logic [19:0] a);
    for (int i = 0; i < 3; i++) begin
      host.beat(1'b0, 1'b1, 1'b0, 4'hf, a, '0);
      host.sel = bad[i];
      host.beat(1'b0, 1'b1, 1'b0, 4'hf, a, '0);
      @(negedge i_ref_clk);
      check("selected", 36'(o_dq_oe), 36'h1);
      host.sel = 3'b010;
      host.beat(1'b0, 1'b0, 1'b0, 4'hf, a, '0);
      @(negedge i_ref_clk);
      check("deselected", 36'(o_dq_oe), 36'h0);
    end
  endtask : t_desel

  // ----------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------
  initial begin
    failures = 0;
    samples_checked = 0;
    i_rst = 1'b1;
    repeat (12) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    for (int i = 0; i < 2; i++) begin
      t_burst(1'b1, base[i], i[0]);
      t_burst(1'b0, base[i], 1'b0);
      t_burst(1'b0, base[i], 1'b1);
    end
    t_hold_proc(base[0], {base[0][19:2], 2'b10});
    t_async(base[1]);
    t_desel(base[0]);
    end_sim();
  end

  initial begin
    repeat (400) @(posedge i_ref_clk);
    failures++;
    end_sim();
  end
endmodule : testbench
